// >>> taprc_map.svh
// constants for the test access port reset control link
`ifndef TAPRC_MAP_SVH
`define TAPRC_MAP_SVH

// instruction register width and codes
`define TAPRC_IR_W          4
`define TAPRC_IR_USER       4'h2
`define TAPRC_IR_CAPTURE    4'h1
// user test data register width
`define TAPRC_DR_W          8
// ones on mode-select that force the controller to test-logic reset
`define TAPRC_RESET_ONES    5
// timing: local clock and test clock periods in ns
`define TAPRC_CLK_NS        40
`define TAPRC_TCK_NS        320
// local clocks per test clock half period
`define TAPRC_TCK_HALF      ((`TAPRC_TCK_NS / `TAPRC_CLK_NS) / 2)
// test clock periods the host holds the test reset low
`define TAPRC_TRST_TCKS     4

`endif

// >>> taprc_pkg.sv
// types shared by both ends of the test access port link
package taprc_pkg;

  // sixteen controller states, standard encoding
  typedef enum logic [3:0] {
    TAPRC_EXIT2_DR  = 4'h0,
    TAPRC_EXIT1_DR  = 4'h1,
    TAPRC_SHIFT_DR  = 4'h2,
    TAPRC_PAUSE_DR  = 4'h3,
    TAPRC_SEL_IR    = 4'h4,
    TAPRC_UPDATE_DR = 4'h5,
    TAPRC_CAPT_DR   = 4'h6,
    TAPRC_SEL_DR    = 4'h7,
    TAPRC_EXIT2_IR  = 4'h8,
    TAPRC_EXIT1_IR  = 4'h9,
    TAPRC_SHIFT_IR  = 4'ha,
    TAPRC_PAUSE_IR  = 4'hb,
    TAPRC_IDLE      = 4'hc,
    TAPRC_UPDATE_IR = 4'hd,
    TAPRC_CAPT_IR   = 4'he,
    TAPRC_TLR       = 4'hf
  } taprc_state_t;

  // host commands
  typedef enum logic [1:0] {
    TAPRC_OP_PIN_RESET = 2'h0,
    TAPRC_OP_TMS_RESET = 2'h1,
    TAPRC_OP_SCAN_IR   = 2'h2,
    TAPRC_OP_SCAN_DR   = 2'h3
  } taprc_op_t;

  // host sequencer states
  typedef enum logic [1:0] {
    TAPRC_H_PINRST = 2'h0,
    TAPRC_H_IDLE   = 2'h1,
    TAPRC_H_RUN    = 2'h2,
    TAPRC_H_DONE   = 2'h3
  } taprc_hstate_t;

endpackage

// >>> taprc_link_if.sv
// four-wire test link plus result line between host and device
`timescale 1ns/1ps
interface taprc_link_if;
  logic tck;       // test clock, made by the host
  logic tms;       // mode select
  logic tdi;       // test data into device
  logic trst_n;    // test reset, active low
  logic tdo_o;     // device result drive value
  logic tdo_oe_n;  // device result drive enable, low while driving
  logic tdo;       // resolved result wire, weak pull-up when undriven

  assign tdo = tdo_oe_n ? 1'b1 : tdo_o;

  modport dev  (input tck, tms, tdi, trst_n, output tdo_o, tdo_oe_n);
  modport host (output tck, tms, tdi, trst_n, input tdo);
endinterface

// >>> taprc_dev.sv
// device end: test access port controller with reset and enable control
// Function
// - low test reset disables port, resets controller asynchronously
// - that reset also clears remaining test logic
// - mode-select steers controller state transitions
// - controller state runs only on test clock
// - scans need a controller reset first
// - host keeps test reset high during operation
// - host never drives mode-select low during reset
// - host pulses test reset low before operation
// - five mode-select highs reset controller synchronously
// - controller reset loads the bypass instruction
// - in test-logic reset, test logic stays inactive
`timescale 1ns/1ps
`include "taprc_map.svh"
module taprc_dev #(
  parameter int IR_W = `TAPRC_IR_W,
  parameter int DR_W = `TAPRC_DR_W
) (
  // system
  input  wire logic                  clk,
  input  wire logic                  rst,
  // test link
  taprc_link_if.dev                  link,
  // user side
  input  wire logic [DR_W-1:0]       dr_capture,
  output logic      [DR_W-1:0]       dr_update,
  output taprc_pkg::taprc_state_t    tap_state,
  output logic      [IR_W-1:0]       instr,
  output logic                       test_logic_reset
);
  import taprc_pkg::*;

  // all-ones instruction selects the bypass bit
  localparam logic [IR_W-1:0] BYPASS_INSTR = {IR_W{1'b1}};
  localparam logic [IR_W-1:0] USER_INSTR   = IR_W'(`TAPRC_IR_USER);
  localparam logic [IR_W-1:0] CAPT_PAT     = IR_W'(`TAPRC_IR_CAPTURE);

  // standard controller transition on one sampled mode-select level
  function automatic taprc_state_t tap_next(input taprc_state_t s, input logic m);
    taprc_state_t n;
    n = s;
    unique case (s)
      TAPRC_TLR:       n = m ? TAPRC_TLR       : TAPRC_IDLE;
      TAPRC_IDLE:      n = m ? TAPRC_SEL_DR    : TAPRC_IDLE;
      TAPRC_SEL_DR:    n = m ? TAPRC_SEL_IR    : TAPRC_CAPT_DR;
      TAPRC_CAPT_DR:   n = m ? TAPRC_EXIT1_DR  : TAPRC_SHIFT_DR;
      TAPRC_SHIFT_DR:  n = m ? TAPRC_EXIT1_DR  : TAPRC_SHIFT_DR;
      TAPRC_EXIT1_DR:  n = m ? TAPRC_UPDATE_DR : TAPRC_PAUSE_DR;
      TAPRC_PAUSE_DR:  n = m ? TAPRC_EXIT2_DR  : TAPRC_PAUSE_DR;
      TAPRC_EXIT2_DR:  n = m ? TAPRC_UPDATE_DR : TAPRC_SHIFT_DR;
      TAPRC_UPDATE_DR: n = m ? TAPRC_SEL_DR    : TAPRC_IDLE;
      TAPRC_SEL_IR:    n = m ? TAPRC_TLR       : TAPRC_CAPT_IR;
      TAPRC_CAPT_IR:   n = m ? TAPRC_EXIT1_IR  : TAPRC_SHIFT_IR;
      TAPRC_SHIFT_IR:  n = m ? TAPRC_EXIT1_IR  : TAPRC_SHIFT_IR;
      TAPRC_EXIT1_IR:  n = m ? TAPRC_UPDATE_IR : TAPRC_PAUSE_IR;
      TAPRC_PAUSE_IR:  n = m ? TAPRC_EXIT2_IR  : TAPRC_PAUSE_IR;
      TAPRC_EXIT2_IR:  n = m ? TAPRC_UPDATE_IR : TAPRC_SHIFT_IR;
      TAPRC_UPDATE_IR: n = m ? TAPRC_SEL_DR    : TAPRC_IDLE;
    endcase
    return n;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers, on the local clock
  // ---------------------------------------------------------------
  logic [1:0] tck_sync;   // test clock, stage 0 read only by stage 1
  logic [1:0] tms_sync;   // mode select
  logic [1:0] tdi_sync;   // test data in
  logic       tck_d;      // synchronised test clock, one cycle late
  logic       tck_rise;   // rising test clock edge seen
  logic       tck_fall;   // falling test clock edge seen

  // two flops per clock, mode-select and data pin before any logic looks at it; test reset is used raw
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tck_sync <= 2'h0;
      tms_sync <= 2'h3;
      tdi_sync <= 2'h3;
      tck_d    <= 1'b0;
    end else begin
      tck_sync <= {tck_sync[0], link.tck};
      tms_sync <= {tms_sync[0], link.tms};
      tdi_sync <= {tdi_sync[0], link.tdi};
      tck_d    <= tck_sync[1];
    end
  end

  // edges of the test clock time every controller step
  assign tck_rise = tck_sync[1] & ~tck_d;
  assign tck_fall = ~tck_sync[1] & tck_d;

  // ---------------------------------------------------------------
  // test reset: raw pin clears the controller without any clock
  // ---------------------------------------------------------------
  logic tap_arst;  // asynchronous clear of all test logic

  // low test reset, or system reset, clears everything at once
  assign tap_arst = rst | ~link.trst_n;

  // ---------------------------------------------------------------
  // controller and test registers
  // ---------------------------------------------------------------
  taprc_state_t    state, next_state;       // controller state
  logic [IR_W-1:0] ir, next_ir;             // active instruction
  logic [IR_W-1:0] ir_sh, next_ir_sh;       // instruction shift stage
  logic            bypass, next_bypass;     // bypass bit
  logic [DR_W-1:0] dr_sh, next_dr_sh;       // user data shift stage
  logic [DR_W-1:0] dr_upd, next_dr_upd;     // user data parallel output
  logic            tdo_q, next_tdo_q;       // result drive value
  logic            tdo_oe_q, next_tdo_oe_q; // result enable, low drives
  logic            tlr_q, next_tlr_q;       // test-logic reset flag
  logic            user_sel;                // user register selected

  assign user_sel = (ir == USER_INSTR);

  // next values, stepped only on test clock edges
  always_comb begin
    next_state    = state;
    next_ir       = ir;
    next_ir_sh    = ir_sh;
    next_bypass   = bypass;
    next_dr_sh    = dr_sh;
    next_dr_upd   = dr_upd;
    next_tdo_q    = tdo_q;
    next_tdo_oe_q = tdo_oe_q;
    // rising edge: move on mode-select, act in current state
    if (tck_rise) begin
      // five highs from any state land in test-logic reset
      next_state = tap_next(state, tms_sync[1]);
      // capture fixed pattern into instruction stage
      if (state == TAPRC_CAPT_IR) begin
        next_ir_sh = CAPT_PAT;
      end
      // shift instruction stage toward the result pin
      if (state == TAPRC_SHIFT_IR) begin
        next_ir_sh = {tdi_sync[1], ir_sh[IR_W-1:1]};
      end
      // new instruction takes effect
      if (state == TAPRC_UPDATE_IR) begin
        next_ir = ir_sh;
      end
      // capture: user word or cleared bypass bit
      if (state == TAPRC_CAPT_DR) begin
        if (user_sel) begin
          next_dr_sh = dr_capture;
        end else begin
          next_bypass = 1'b0;
        end
      end
      // shift the selected data register
      if (state == TAPRC_SHIFT_DR) begin
        if (user_sel) begin
          next_dr_sh = {tdi_sync[1], dr_sh[DR_W-1:1]};
        end else begin
          next_bypass = tdi_sync[1];
        end
      end
      // publish the user word
      if (state == TAPRC_UPDATE_DR && user_sel) begin
        next_dr_upd = dr_sh;
      end
      // test-logic reset keeps bypass loaded and test logic quiet
      if (state == TAPRC_TLR) begin
        next_ir = BYPASS_INSTR;
      end
    end
    // falling edge: drive result only while shifting
    if (tck_fall) begin
      if (state == TAPRC_SHIFT_IR) begin
        next_tdo_q    = ir_sh[0];
        next_tdo_oe_q = 1'b0;
      end else if (state == TAPRC_SHIFT_DR) begin
        next_tdo_q    = user_sel ? dr_sh[0] : bypass;
        next_tdo_oe_q = 1'b0;
      end else begin
        next_tdo_oe_q = 1'b1;
      end
    end
    // flag follows the state that is being entered
    next_tlr_q = (next_state == TAPRC_TLR);
  end

  // registers, all cleared by the test reset pin without a clock
  always_ff @(posedge clk or posedge tap_arst) begin
    if (tap_arst) begin
      state    <= TAPRC_TLR;
      ir       <= BYPASS_INSTR;
      ir_sh    <= {IR_W{1'b0}};
      bypass   <= 1'b0;
      dr_sh    <= {DR_W{1'b0}};
      dr_upd   <= {DR_W{1'b0}};
      tdo_q    <= 1'b1;
      tdo_oe_q <= 1'b1;          // port disabled, result pin released
      tlr_q    <= 1'b1;
    end else begin
      state    <= next_state;
      ir       <= next_ir;
      ir_sh    <= next_ir_sh;
      bypass   <= next_bypass;
      dr_sh    <= next_dr_sh;
      dr_upd   <= next_dr_upd;
      tdo_q    <= next_tdo_q;
      tdo_oe_q <= next_tdo_oe_q;
      tlr_q    <= next_tlr_q;
    end
  end

  // outputs straight from flops
  assign link.tdo_o        = tdo_q;
  assign link.tdo_oe_n     = tdo_oe_q;
  assign dr_update         = dr_upd;
  assign tap_state         = state;
  assign instr             = ir;
  assign test_logic_reset  = tlr_q;

endmodule // taprc_dev

// >>> taprc_host.sv
// host end: makes test clock, resets the controller, runs scans
`timescale 1ns/1ps
`include "taprc_map.svh"
module taprc_host #(
  parameter int IR_W = `TAPRC_IR_W,
  parameter int DR_W = `TAPRC_DR_W,
  parameter int HALF = `TAPRC_TCK_HALF
) (
  // system
  input  wire logic                  clk,
  input  wire logic                  rst,
  // test link
  taprc_link_if.host                 link,
  // command
  input  wire logic                  cmd_valid,
  input  taprc_pkg::taprc_op_t       cmd_op,
  input  wire logic [DR_W-1:0]       cmd_data,
  output logic                       cmd_ready,
  // response
  output logic                       rsp_valid,
  output logic                       rsp_err,
  output logic      [DR_W-1:0]       rsp_data,
  output logic                       reset_done
);
  import taprc_pkg::*;

  localparam int CW = $clog2(HALF + 1);
  localparam int KW = 8;

  // result pin synchroniser, stage 0 read only by stage 1
  logic [1:0] tdo_sync;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) tdo_sync <= 2'h3;
    else     tdo_sync <= {tdo_sync[0], link.tdo};
  end

  taprc_hstate_t   hs, next_hs;           // sequencer state
  logic [CW-1:0]   div, next_div;         // half-period divider
  logic            tck, next_tck;         // test clock out
  logic            tms, next_tms;         // mode select out
  logic            tdi, next_tdi;         // data out
  logic            trst_n, next_trst_n;   // test reset out
  logic [KW-1:0]   k, next_k;             // bit index in sequence
  logic [7:0]      pre, next_pre;         // lead-in mode-select bits
  logic [3:0]      pre_len, next_pre_len; // lead-in length
  logic [KW-1:0]   n, next_n;             // shift length
  logic [DR_W-1:0] tx, next_tx;           // data to shift out
  logic [DR_W-1:0] rx, next_rx;           // data shifted in
  logic            smp, next_smp;         // sample result at next fall
  logic            err, next_err;         // command refused
  logic            vld, next_vld;         // response pulse
  logic            done, next_done;       // controller reset seen
  logic            rdy, next_rdy;         // command port ready, from a flop
  logic            edge_now;              // divider wraps this cycle
  logic [KW-1:0]   total;                 // sequence length

  assign edge_now = (div == CW'(HALF - 1));
  assign total    = KW'(pre_len) + n + ((n != '0) ? KW'(2) : KW'(0));

  // sequencer next values
  always_comb begin
    next_hs = hs; next_div = edge_now ? '0 : div + CW'(1);
    next_tck = edge_now ? ~tck : tck;
    next_tms = tms; next_tdi = tdi; next_trst_n = trst_n;
    next_k = k; next_pre = pre; next_pre_len = pre_len; next_n = n;
    next_tx = tx; next_rx = rx; next_smp = smp; next_err = err;
    next_vld = 1'b0; next_done = done;
    unique case (hs)
      // pin reset: test reset low, mode-select held high
      TAPRC_H_PINRST: begin
        next_tms = 1'b1;
        next_trst_n = 1'b0;
        if (edge_now && tck && k == KW'(`TAPRC_TRST_TCKS - 1)) begin
          next_trst_n = 1'b1;
          next_done = 1'b1;
          next_hs = TAPRC_H_DONE;
        end else if (edge_now && tck) begin
          next_k = k + KW'(1);
        end
      end
      // take a command
      TAPRC_H_IDLE: begin
        next_k = '0; next_err = 1'b0; next_smp = 1'b0;
        if (cmd_valid) begin
          next_tx = cmd_data;
          next_hs = TAPRC_H_RUN;
          unique case (cmd_op)
            TAPRC_OP_PIN_RESET: next_hs = TAPRC_H_PINRST;
            TAPRC_OP_TMS_RESET: begin
              next_pre = 8'h1f; next_pre_len = 4'h6; next_n = '0;
            end
            TAPRC_OP_SCAN_IR: begin
              next_pre = 8'h06; next_pre_len = 4'h5; next_n = KW'(IR_W);
            end
            TAPRC_OP_SCAN_DR: begin
              next_pre = 8'h02; next_pre_len = 4'h4; next_n = KW'(DR_W);
            end
          endcase
          // scans before any controller reset are refused
          if (!done && cmd_op[1]) begin
            next_err = 1'b1;
            next_hs = TAPRC_H_DONE;
          end
        end
      end
      // one bit per falling edge; the result of the last bit is taken just
      // before the next fall, as both synchronisers make it late for the rise
      TAPRC_H_RUN: begin
        if (edge_now && tck) begin
          if (smp) begin
            next_rx = {tdo_sync[1], rx[DR_W-1:1]};
          end
          next_smp = 1'b0;
          if (k == total) begin
            next_hs = TAPRC_H_DONE;
            if (n == '0) next_done = 1'b1;
          end else if (k < KW'(pre_len)) begin
            next_tms = pre[k[2:0]];
          end else if (k < KW'(pre_len) + n) begin
            next_tms = (k == KW'(pre_len) + n - KW'(1));
            next_tdi = tx[0];
            next_tx = tx >> 1;
            next_smp = 1'b1;
          end else begin
            next_tms = (k == KW'(pre_len) + n);
          end
          next_k = k + KW'(1);
        end
      end
      // respond, align captured bits low
      TAPRC_H_DONE: begin
        next_vld = 1'b1;
        if (n != '0) next_rx = rx >> (KW'(DR_W) - n);
        next_hs = TAPRC_H_IDLE;
      end
    endcase
    // ready follows the state being entered
    next_rdy = (next_hs == TAPRC_H_IDLE);
  end

  // sequencer registers; power-up starts with a pin reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs <= TAPRC_H_PINRST; div <= '0; tck <= 1'b0; tms <= 1'b1;
      tdi <= 1'b1; trst_n <= 1'b0; k <= '0; pre <= 8'h00;
      pre_len <= 4'h0; n <= '0; tx <= '0; rx <= '0; smp <= 1'b0;
      err <= 1'b0; vld <= 1'b0; done <= 1'b0;
      rdy <= 1'b0;
    end else begin
      hs <= next_hs; div <= next_div; tck <= next_tck; tms <= next_tms;
      tdi <= next_tdi; trst_n <= next_trst_n; k <= next_k; pre <= next_pre;
      pre_len <= next_pre_len; n <= next_n; tx <= next_tx; rx <= next_rx;
      smp <= next_smp; err <= next_err; vld <= next_vld; done <= next_done;
      rdy <= next_rdy;
    end
  end

  // outputs straight from flops
  assign link.tck    = tck;
  assign link.tms    = tms;
  assign link.tdi    = tdi;
  assign link.trst_n = trst_n;
  assign cmd_ready   = rdy;
  assign rsp_valid   = vld;
  assign rsp_err     = err;
  assign rsp_data    = rx;
  assign reset_done  = done;

endmodule // taprc_host

// >>> taprc_assertions.sv
// wire-level checker for the test link between host and device
`timescale 1ns/1ps
module taprc_assertions (
  // system
  input wire logic clk,
  input wire logic rst,
  // test link
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  input wire logic tdo_o,
  input wire logic tdo_oe_n
);
  // every check runs on the local clock, quiet while in reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // mode-select stays high for as long as the test reset is low
  chk_trst_tms_high: assert property (!trst_n |-> tms)
    else $error("mode select low during test reset");
  // test reset pulse is long enough and ends in bounded time
  chk_trst_pulse_len: assert property (
    $fell(trst_n) |-> (!trst_n)[*8] ##[1:40] trst_n)
    else $error("test reset pulse length wrong");
  // device never drives its result while held in test reset
  chk_trst_quiet: assert property (!trst_n |-> tdo_oe_n)
    else $error("result driven during test reset");
  // after test reset ends the device stays quiet for a while
  chk_release_quiet: assert property ($rose(trst_n) |-> tdo_oe_n[*8])
    else $error("result driven right after test reset");
  // test clock high phase is four local clocks, as set in the bench
  chk_tck_half_len: assert property ($rose(tck) |-> tck[*4] ##1 !tck)
    else $error("test clock high phase wrong");
  // mode select and data do not move while the test clock is high
  chk_tms_hold_high: assert property (
    tck && $past(tck) && trst_n |-> $stable(tms) && $stable(tdi))
    else $error("mode select or data moved in high phase");
  // result enable only changes in the low phase of the test clock
  chk_oe_low_phase: assert property ($changed(tdo_oe_n) && trst_n |-> !tck)
    else $error("result enable moved in high phase");
  // a driven result bit holds through the high phase
  chk_tdo_steady: assert property (
    !tdo_oe_n && $past(tdo_oe_n) == 1'b0 && tck |-> $stable(tdo_o))
    else $error("result bit moved in high phase");

  // main scenarios
  cov_pin_reset: cover property ($fell(trst_n));
  cov_shift_out: cover property ($fell(tdo_oe_n));
  cov_scan_after_reset: cover property ($rose(trst_n) ##[1:100] $fell(tdo_oe_n));
endmodule // taprc_assertions

// >>> taprc_test.sv
// self-checking bench for host and device joined over the test link
`timescale 1ns/1ps
`include "taprc_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module taprc_test;
  import taprc_pkg::*;
  localparam int DW = `TAPRC_DR_W;
  localparam int IW = `TAPRC_IR_W;
  // clock and reset
  logic                   clk;
  logic                   rst;
  // host command side
  logic                   cmd_valid;
  taprc_op_t              cmd_op;
  logic [DW-1:0]          cmd_data;
  logic                   cmd_ready;
  logic                   rsp_valid;
  logic                   rsp_err;
  logic [DW-1:0]          rsp_data;
  logic                   reset_done;
  // device user side
  logic [DW-1:0]          dr_capture;
  logic [DW-1:0]          dr_update;
  taprc_state_t           tap_state;
  logic [IW-1:0]          instr;
  logic                   test_logic_reset;
  // bookkeeping
  int                     mismatches;
  int                     n_tests;
  logic [31:0]            seed;
  logic [DW-1:0]          d;

  taprc_link_if taprc_link_if_inst ();

  taprc_dev #(.IR_W(IW), .DR_W(DW)) taprc_dev_inst (
    .clk(clk), .rst(rst), .link(taprc_link_if_inst),
    .dr_capture(dr_capture), .dr_update(dr_update), .tap_state(tap_state),
    .instr(instr), .test_logic_reset(test_logic_reset));

  taprc_host #(.IR_W(IW), .DR_W(DW), .HALF(`TAPRC_TCK_HALF)) taprc_host_inst (
    .clk(clk), .rst(rst), .link(taprc_link_if_inst),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
    .rsp_data(rsp_data), .reset_done(reset_done));

  taprc_assertions taprc_assertions_inst (
    .clk(clk), .rst(rst), .tck(taprc_link_if_inst.tck),
    .tms(taprc_link_if_inst.tms), .tdi(taprc_link_if_inst.tdi),
    .trst_n(taprc_link_if_inst.trst_n), .tdo_o(taprc_link_if_inst.tdo_o),
    .tdo_oe_n(taprc_link_if_inst.tdo_oe_n));

  // 25 MHz local clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // next random word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // bypass path: one zero first, then the data one bit late
  function automatic logic [DW-1:0] bypass_out(input logic [DW-1:0] v);
    return {v[DW-2:0], 1'b0};
  endfunction

  // print counts and verdict, then stop
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // wait for the response pulse, bounded
  task automatic wait_rsp();
    int i;
    i = 0;
    while (rsp_valid !== 1'b1 && i < 500) begin
      @(posedge clk);
      #1;
      i++;
    end
    // a missing answer ends the run as a failure
    if (i >= 500) begin
      mismatches++;
      test_done();
    end
  endtask

  // hand one command to the host once it is ready
  task automatic start_cmd(input taprc_op_t op, input logic [DW-1:0] v);
    int i;
    i = 0;
    while (cmd_ready !== 1'b1 && i < 500) begin
      @(posedge clk);
      #1;
      i++;
    end
    // a host that never gets ready ends the run as a failure
    if (i >= 500) begin
      mismatches++;
      test_done();
    end
    cmd_op = op;
    cmd_data = v;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
  endtask

  // full command and wait for its answer
  task automatic cmd(input taprc_op_t op, input logic [DW-1:0] v);
    start_cmd(op, v);
    wait_rsp();
  endtask

  // device sits in test-logic reset with bypass selected
  task automatic check_reset_state();
    `CHK(tap_state, TAPRC_TLR)
    `CHK(instr, {IW{1'b1}})
    `CHK(test_logic_reset, 1'b1)
    `CHK(dr_update, {DW{1'b0}})
  endtask

  // while the test reset pin is low the controller is held reset
  always @(negedge clk) begin
    if (rst === 1'b0 && taprc_link_if_inst.trst_n === 1'b0) begin
      `CHK(tap_state, TAPRC_TLR)
      `CHK(instr, {IW{1'b1}})
    end
  end

  // watchdog against a hang
  initial begin
    #(40 * 20000);
    mismatches++;
    test_done();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = TAPRC_OP_PIN_RESET;
    cmd_data = '0;
    dr_capture = '0;
    seed = 32'he4fd;
    mismatches = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    // host runs its own pin reset after release
    wait_rsp();
    `CHK(rsp_err, 1'b0)
    `CHK(reset_done, 1'b1)
    `CHK(cmd_ready, 1'b1)
    check_reset_state();
    // five highs then a low: reset, then idle
    cmd(TAPRC_OP_TMS_RESET, '0);
    `CHK(tap_state, TAPRC_IDLE)
    `CHK(instr, {IW{1'b1}})
    `CHK(test_logic_reset, 1'b0)
    // data scans through bypass
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      cmd(TAPRC_OP_SCAN_DR, seed[DW-1:0]);
      `CHK(rsp_data, bypass_out(seed[DW-1:0]))
    end
    // load the user instruction
    cmd(TAPRC_OP_SCAN_IR, DW'(`TAPRC_IR_USER));
    `CHK(rsp_data[IW-1:0], `TAPRC_IR_CAPTURE)
    `CHK(instr, `TAPRC_IR_USER)
    // user scans: all zero and all ones corners, then random
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      d = (k == 0) ? '0 : (k == 1) ? '1 : seed[DW-1:0];
      seed = lfsr(seed);
      dr_capture = (k == 0) ? '1 : seed[DW-1:0];
      cmd(TAPRC_OP_SCAN_DR, d);
      `CHK(rsp_data, dr_capture)
      `CHK(dr_update, d)
      `CHK(tap_state, TAPRC_IDLE)
    end
    // five highs from run-test idle drop the user instruction to bypass
    cmd(TAPRC_OP_TMS_RESET, '0);
    `CHK(instr, {IW{1'b1}})
    `CHK(tap_state, TAPRC_IDLE)
    // reload the user instruction for the pin reset below
    cmd(TAPRC_OP_SCAN_IR, DW'(`TAPRC_IR_USER));
    `CHK(instr, `TAPRC_IR_USER)
    // pin reset drops the user instruction back to bypass
    cmd(TAPRC_OP_PIN_RESET, '0);
    `CHK(rsp_err, 1'b0)
    check_reset_state();
    // scan straight out of test-logic reset
    seed = lfsr(seed);
    cmd(TAPRC_OP_SCAN_DR, seed[DW-1:0]);
    `CHK(rsp_data, bypass_out(seed[DW-1:0]))
    // second reset in the middle of a scan
    start_cmd(TAPRC_OP_SCAN_DR, 8'h5a);
    repeat (30) @(posedge clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK(tap_state, TAPRC_TLR)
    rst = 1'b0;
    wait_rsp();
    `CHK(rsp_err, 1'b0)
    check_reset_state();
    test_done();
  end
endmodule // taprc_test
